// >>> rtl/vecr_pkg.sv
// constants shared by the video encoder configuration register bank
package vecr_pkg;

  // ---------------------------------------------------------------
  // serial port addressing and byte length
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_PRIMARY = 7'h44;
  localparam logic [6:0] ADDR_ALT     = 7'h46;
  localparam logic [3:0] BITS_BYTE    = 4'h8;

  // ---------------------------------------------------------------
  // subaddresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SA_WSS_LO  = 8'h26;
  localparam logic [7:0] SA_WSS_HI  = 8'h27;
  localparam logic [7:0] SA_BURST_S = 8'h28;
  localparam logic [7:0] SA_BURST_E = 8'h29;
  localparam logic [7:0] SA_CG_O0   = 8'h2A;
  localparam logic [7:0] SA_CG_O1   = 8'h2B;
  localparam logic [7:0] SA_CG_E0   = 8'h2C;
  localparam logic [7:0] SA_CG_E1   = 8'h2D;
  localparam logic [7:0] SA_CG_EN   = 8'h2E;
  localparam logic [7:0] SA_IN_FMT  = 8'h3A;
  localparam logic [7:0] SA_PHASE   = 8'h5A;
  localparam logic [7:0] SA_U_GAIN   = 8'h5B;
  localparam logic [7:0] SA_U_GAIN_T = 8'h5D;
  localparam logic [7:0] SA_STD     = 8'h61;
  localparam logic [7:0] SA_RTC     = 8'h62;

  // ---------------------------------------------------------------
  // reset values and copy guard bit count
  // ---------------------------------------------------------------
  localparam logic [5:0] RST_BURST_S = 6'h21;
  localparam logic [5:0] RST_BURST_E = 6'h1D;
  localparam logic [7:0] RST_IN_FMT  = 8'h03;
  localparam logic [4:0] CG_BITS     = 5'h10;

endpackage

// >>> rtl/vecr_config_regs.sv
// serial-port configuration register bank of the video encoder
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - answer only the two fixed slave addresses
// - address LSB: 0 write, 1 read
// - start, address, subaddress, data, stop; ack each
// - subaddress advances after every data byte
// - signalling word output whole as 14 bits, built from two registers
// - signalling word always driven; output-on flag sent beside it
// - burst start count, reset 33
// - burst end count, reset 29
// - colour detect from link when selected, enabled
// - field sequence from register or link
// - copy guard bytes sent LSB first
// - copy guard field enable coding
// - chroma format bit, reset straight binary
// - luma format bit, reset straight binary
// - sync source 0 uses sync pins
// - sync source 1 uses embedded codes
// - colour bar bit selects fixed pattern
// - eight-bit subcarrier phase offset
// - U gain scales blue difference
// - U gain ninth bit at 5DH bit 7
// - link enable bit at 62H bit 7
module vecr_config_regs (
  input  wire logic        clk_i,         // 20 MHz clock
  input  wire logic        rst_i,         // sync reset, high
  input  wire logic        scl_i,         // serial clock pin
  input  wire logic        sda_i,         // serial data pin in
  output logic             sda_o,         // serial data out
  output logic             sda_oe_o,      // pull data line low
  input  wire logic        horizontal_sync_pin_i, // h pin
  input  wire logic        vertical_sync_pin_i,   // v pin
  input  wire logic        embedded_h_trig_i,     // decoded h
  input  wire logic        embedded_v_trig_i,     // decoded v
  input  wire logic        realtime_control_input_colour_i,     // link colour bit
  input  wire logic        realtime_control_input_field_seq_i,  // link field bit
  input  wire logic        field_odd_i,       // current field odd
  input  wire logic        cg_start_i,        // after framing code
  input  wire logic        cg_bit_tick_i,     // next bit slot
  output logic [13:0]      widescreen_signalling_bits_o, // word
  output logic             widescreen_output_on_o,  // emit enable
  output logic [5:0]       burst_first_cycle_o,     // burst start
  output logic [5:0]       burst_last_cycle_o,      // burst end
  output logic             colour_detect_o,   // chosen colour bit
  output logic             field_seq_o,       // chosen sequence
  output logic             cg_bit_o,          // copy guard bit
  output logic             cg_busy_o,         // serialiser running
  output logic             chroma_format_sel_o, // 1 straight
  output logic             luma_format_sel_o,   // 1 straight
  output logic             h_trig_o,          // selected h trigger
  output logic             v_trig_o,          // selected v trigger
  output logic             colour_bar_select_o, // fixed bars
  output logic [7:0]       subcarrier_phase_offset_o, // phase
  output logic [8:0]       u_gain_o,          // U gain
  output logic [5:0]       black_level_o      // black level
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] hs_s;
  logic [1:0] vs_s;
  logic       scl_d;
  logic       sda_d;

  // two flops per pin; only stage 1 is looked at by logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      hs_s  <= 2'h0;
      vs_s  <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      hs_s  <= {hs_s[0], horizontal_sync_pin_i};
      vs_s  <= {vs_s[0], vertical_sync_pin_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // bus conditions seen on the cleaned lines
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_SKIP
  } vecr_state_t;

  vecr_state_t state;
  logic [7:0]  shreg;
  logic [3:0]  bit_cnt;
  logic [7:0]  subaddr;
  logic        ack_drive;
  logic        addr_hit;
  logic        wr_en;

  assign addr_hit = (shreg[7:1] == vecr_pkg::ADDR_PRIMARY) ||
                    (shreg[7:1] == vecr_pkg::ADDR_ALT);
  // a data byte lands when its ack begins
  assign wr_en = scl_fall && (bit_cnt == vecr_pkg::BITS_BYTE) &&
                 !ack_drive && (state == ST_DATA);

  // byte framing, ack timing and subaddress tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i || stop_c)
    begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      ack_drive <= 1'b0;
      shreg     <= 8'h00;
      subaddr   <= 8'h00;
    end
    else if (start_c)
    begin
      state     <= ST_ADDR;   // repeated start also restarts
      bit_cnt   <= 4'h0;
      ack_drive <= 1'b0;
    end
    else if (state != ST_IDLE && state != ST_SKIP)
    begin
      if (scl_rise && bit_cnt != vecr_pkg::BITS_BYTE)
      begin
        shreg   <= {shreg[6:0], sda_s[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_fall && bit_cnt == vecr_pkg::BITS_BYTE)
      begin
        if (!ack_drive)
        begin
          // foreign address: stay silent until the next start
          if (state == ST_ADDR && !addr_hit)
            state <= ST_SKIP;
          else
            ack_drive <= 1'b1; // every taken byte is acked
          if (state == ST_SUB)
            subaddr <= shreg;
        end
        else
        begin
          ack_drive <= 1'b0;
          bit_cnt   <= 4'h0;
          unique case (state)
            // read path is not built: line stays released
            ST_ADDR: state <= shreg[0] ? ST_SKIP : ST_SUB;
            ST_SUB:  state <= ST_DATA;
            ST_DATA: subaddr <= subaddr + 8'h01;
            default: state <= ST_SKIP;
          endcase
        end
      end
    end
  end

  // data line only ever pulled low, so the driven level stays 0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= ack_drive; // one cycle behind, well inside scl low
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] wss_lo;
  logic [7:0] wss_hi;
  logic [7:0] burst_s;
  logic [7:0] burst_e;
  logic [7:0] cg_o0;
  logic [7:0] cg_o1;
  logic [7:0] cg_e0;
  logic [7:0] cg_e1;
  logic [1:0] cg_en;
  logic [7:0] in_fmt;
  logic [7:0] phase;
  logic [7:0] u_gain_lo;
  logic [7:0] u_gain_top;
  logic       line_len_sel;
  logic       rtc_en;

  // unmapped subaddresses fall through and are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wss_lo       <= 8'h00;
      wss_hi       <= 8'h00;             // output off
      burst_s      <= {2'h0, vecr_pkg::RST_BURST_S};
      burst_e      <= {2'h0, vecr_pkg::RST_BURST_E};
      cg_o0        <= 8'h00;
      cg_o1        <= 8'h00;
      cg_e0        <= 8'h00;
      cg_e1        <= 8'h00;
      cg_en        <= 2'h0;
      in_fmt       <= vecr_pkg::RST_IN_FMT;
      phase        <= 8'h00;
      u_gain_lo     <= 8'h00;
      u_gain_top    <= 8'h00;
      line_len_sel <= 1'b0;
      rtc_en       <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (subaddr)
        vecr_pkg::SA_WSS_LO:  wss_lo    <= shreg;
        vecr_pkg::SA_WSS_HI:  wss_hi    <= shreg;
        vecr_pkg::SA_BURST_S: burst_s   <= shreg;
        vecr_pkg::SA_BURST_E: burst_e   <= shreg;
        vecr_pkg::SA_CG_O0:   cg_o0     <= shreg;
        vecr_pkg::SA_CG_O1:   cg_o1     <= shreg;
        vecr_pkg::SA_CG_E0:   cg_e0     <= shreg;
        vecr_pkg::SA_CG_E1:   cg_e1     <= shreg;
        vecr_pkg::SA_CG_EN:   cg_en     <= shreg[7:6];
        vecr_pkg::SA_IN_FMT:  in_fmt    <= shreg;
        vecr_pkg::SA_PHASE:   phase     <= shreg;
        vecr_pkg::SA_U_GAIN:   u_gain_lo  <= shreg;
        vecr_pkg::SA_U_GAIN_T: u_gain_top <= shreg;
        vecr_pkg::SA_STD:     line_len_sel <= shreg[0];
        vecr_pkg::SA_RTC:     rtc_en    <= shreg[7];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // field outputs
  // ---------------------------------------------------------------
  // all outputs registered; fields follow their register a cycle on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      widescreen_signalling_bits_o <= 14'h0000;
      widescreen_output_on_o       <= 1'b0;
      burst_first_cycle_o          <= vecr_pkg::RST_BURST_S;
      burst_last_cycle_o           <= vecr_pkg::RST_BURST_E;
      chroma_format_sel_o          <= 1'b1;
      luma_format_sel_o            <= 1'b1;
      colour_bar_select_o          <= 1'b0;
      subcarrier_phase_offset_o    <= 8'h00;
      u_gain_o                     <= 9'h000;
      black_level_o                <= 6'h00;
    end
    else
    begin
      // aspect 3..0, services 7..4, subtitles 10..8, spare 13..11
      widescreen_signalling_bits_o <= {wss_hi[5:0], wss_lo};
      widescreen_output_on_o       <= wss_hi[7];
      burst_first_cycle_o          <= burst_s[5:0];
      burst_last_cycle_o           <= burst_e[5:0];
      chroma_format_sel_o          <= in_fmt[0];
      luma_format_sel_o            <= in_fmt[1];
      colour_bar_select_o          <= in_fmt[7];
      subcarrier_phase_offset_o    <= phase;
      u_gain_o <= {u_gain_top[7], u_gain_lo};
      black_level_o                <= u_gain_top[5:0];
    end
  end

  // link selections only count while the link enable is set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      colour_detect_o <= 1'b0;
      field_seq_o     <= 1'b0;
    end
    else
    begin
      colour_detect_o <= burst_s[7] & rtc_en & realtime_control_input_colour_i;
      field_seq_o <= (burst_s[6] & rtc_en) ? realtime_control_input_field_seq_i
                                           : line_len_sel;
    end
  end

  // sync source: pins by default, embedded codes when selected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      h_trig_o <= 1'b0;
      v_trig_o <= 1'b0;
    end
    else if (in_fmt[4])
    begin
      h_trig_o <= embedded_h_trig_i;
      v_trig_o <= embedded_v_trig_i;
    end
    else
    begin
      h_trig_o <= hs_s[1];
      v_trig_o <= vs_s[1];
    end
  end

  // ---------------------------------------------------------------
  // copy guard serialiser
  // ---------------------------------------------------------------
  logic [15:0] cg_shift;
  logic [4:0]  cg_left;
  logic        cg_field_on;

  // bit 0 of cg_en is the odd-field enable, bit 1 the even one
  assign cg_field_on = field_odd_i ? cg_en[0] : cg_en[1];

  // first byte then second, each LSB first; parity is the host's job
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cg_shift  <= 16'h0000;
      cg_left   <= 5'h00;
      cg_bit_o  <= 1'b0;
      cg_busy_o <= 1'b0;
    end
    else if (cg_start_i && cg_field_on)
    begin
      cg_shift  <= field_odd_i ? {cg_o1, cg_o0}
                               : {cg_e1, cg_e0};
      cg_left   <= vecr_pkg::CG_BITS;
      cg_busy_o <= 1'b1;
    end
    else if (cg_bit_tick_i && cg_left != 5'h00)
    begin
      cg_bit_o  <= cg_shift[0];
      cg_shift  <= {1'b0, cg_shift[15:1]};
      cg_left   <= cg_left - 5'h01;
      cg_busy_o <= (cg_left != 5'h01);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_NO_ACK_FOREIGN: assert property (
    (state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !ack_drive
     && !addr_hit && !start_c && !stop_c) |=> ##1 !sda_oe_o)
    else $error("foreign address was acknowledged");

  AST_ACK_OWN: assert property (
    (state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !ack_drive
     && addr_hit && !start_c && !stop_c) |=> ##1 sda_oe_o)
    else $error("own address not acknowledged");

  AST_READ_NO_SUB: assert property (
    (state == ST_ADDR && ack_drive && scl_fall && shreg[0]
     && !start_c && !stop_c) |=> state == ST_SKIP)
    else $error("read request entered subaddress phase");

  AST_AUTOINC: assert property (
    (state == ST_DATA && ack_drive && scl_fall && !start_c && !stop_c)
    |=> subaddr == $past(subaddr) + 8'h01)
    else $error("subaddress did not advance");

  AST_WSS_WRITE: assert property (
    (wr_en && subaddr == 8'h27) |=> ##1
    (widescreen_signalling_bits_o[13:8] == $past(shreg[5:0], 2)
     && widescreen_output_on_o == $past(shreg[7], 2)))
    else $error("signalling high byte not applied");

  AST_BURST_RESET: assert property (
    $fell(rst_i) |-> (burst_first_cycle_o == 6'h21
                      && burst_last_cycle_o == 6'h1D))
    else $error("burst defaults wrong after reset");

  AST_COLOUR_GATED: assert property (
    !rtc_en |=> !colour_detect_o)
    else $error("colour detect passed with link disabled");

  AST_FIELD_SEQ: assert property (
    !(burst_s[6] && rtc_en) |=>
    field_seq_o == $past(line_len_sel))
    else $error("field sequence not from register");

  AST_CG_OFF: assert property (
    (cg_en == 2'h0 && !cg_busy_o) |=> !cg_busy_o)
    else $error("copy guard ran while disabled");

  AST_SYNC_PIN: assert property (
    !in_fmt[4] |=> h_trig_o == $past(hs_s[1]))
    else $error("horizontal trigger not from pin");

  AST_UNMAPPED: assert property (
    (wr_en && subaddr == 8'h5C) |=> ##1 $stable(u_gain_o)
    && $stable(subcarrier_phase_offset_o))
    else $error("unmapped write changed a field");

  CVR_WRITE: cover property (wr_en ##[1:400] wr_en);
  CVR_READ: cover property (state == ST_ADDR && ack_drive && shreg[0]);
  CVR_CG: cover property (cg_busy_o ##1 !cg_busy_o);

endmodule
`default_nettype wire

// >>> tb/vecr_i2c_host.sv
// bus master model that programs the encoder configuration port
`timescale 1ns/1ps
`default_nettype none
module vecr_i2c_host (
  input  wire logic clk_i, // system clock
  input  wire logic sda_i, // resolved data line
  output logic      scl_o, // serial clock drive
  output logic      sda_o  // data drive, 1 releases the line
);
  // phase length in clocks; raise it to play a slow master
  int phase = 8;
  // released bus, clock stands high outside frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // every change is made at a falling clock edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // start, also serves as repeated start after an ack slot
  task automatic start_cond();
    idle(phase / 2);
    sda_o = 1'b1;
    idle(phase / 2);
    scl_o = 1'b1;
    idle(phase);
    sda_o = 1'b0;
    idle(phase);
    scl_o = 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop_cond();
    idle(phase / 2);
    sda_o = 1'b0;
    idle(phase / 2);
    scl_o = 1'b1;
    idle(phase);
    sda_o = 1'b1;
    idle(phase);
  endtask
  // eight bits msb first, then release and sample the ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      idle(phase / 2);
      sda_o = b[i];
      idle(phase / 2);
      scl_o = 1'b1;
      idle(phase);
      scl_o = 1'b0;
    end
    idle(phase / 2);
    sda_o = 1'b1;
    idle(phase / 2);
    scl_o = 1'b1;
    idle(phase / 2);
    ack = ~sda_i;
    idle(phase / 2);
    scl_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_video_encoder_config_regs.sv
// self-checking bench for the encoder configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_video_encoder_config_regs;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i, rst_i, scl, host_sda, sda_wire, dut_sda, dut_oe;
  logic        hpin, vpin, eh, ev, rc, rf, fodd, cgs, cgt;
  logic [13:0] widescreen_bits_low;
  logic        wss_on, cdet, fseq, cgbit, cgbusy, chf, luf, ht, vt, cbar;
  logic [5:0]  bf, bl, blk;
  logic [7:0]  ph;
  logic [8:0]  ug;
  int          failures = 0;
  int          total_checks = 0;
  // open-drain line with pull-up: low if either party pulls
  assign sda_wire = host_sda & (dut_oe ? dut_sda : 1'b1);
  vecr_i2c_host u_host (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));
  vecr_config_regs u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(dut_sda),
    .sda_oe_o(dut_oe), .horizontal_sync_pin_i(hpin), .vertical_sync_pin_i(vpin),
    .embedded_h_trig_i(eh), .embedded_v_trig_i(ev), .realtime_control_input_colour_i(rc),
    .realtime_control_input_field_seq_i(rf), .field_odd_i(fodd), .cg_start_i(cgs), .cg_bit_tick_i(cgt),
    .widescreen_signalling_bits_o(widescreen_bits_low), .widescreen_output_on_o(wss_on),
    .burst_first_cycle_o(bf), .burst_last_cycle_o(bl), .colour_detect_o(cdet),
    .field_seq_o(fseq), .cg_bit_o(cgbit), .cg_busy_o(cgbusy), .chroma_format_sel_o(chf),
    .luma_format_sel_o(luf), .h_trig_o(ht), .v_trig_o(vt), .colour_bar_select_o(cbar),
    .subcarrier_phase_offset_o(ph), .u_gain_o(ug), .black_level_o(blk));
  // 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error: %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one write frame; reserved bits are always sent as zero
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    logic ack;
    u_host.start_cond();
    u_host.send_byte({vecr_pkg::ADDR_PRIMARY, 1'b0}, ack);
    check("addr ack", 16'(ack), 16'h0001);
    u_host.send_byte(sub, ack);
    check("sub ack", 16'(ack), 16'h0001);
    foreach (d[i])
    begin
      u_host.send_byte(d[i], ack);
      check("data ack", 16'(ack), 16'h0001);
    end
    u_host.stop_cond();
    wait_clk(4);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("burst first", 16'(bf), 16'h0021);
    check("burst last", 16'(bl), 16'h001D);
    check("chroma fmt", 16'(chf), 16'h0001);
    check("luma fmt", 16'(luf), 16'h0001);
    check("wss on", 16'(wss_on), 16'h0000);
    check("colour bar", 16'(cbar), 16'h0000);
    hpin = 1'b1;
    ev = 1'b1;
    wait_clk(6);
    check("h trig", 16'(ht), 16'h0001);
    check("v trig", 16'(vt), 16'h0000);
    $display("test reset done");
  endtask
  // four bytes in one frame land in four consecutive registers
  task automatic t_autoinc();
    wr(8'h26, '{8'hA5, 8'h95, 8'h19, 8'h1D});
    check("wss word", 16'(widescreen_bits_low), 16'h15A5);
    check("wss on", 16'(wss_on), 16'h0001);
    check("burst first", 16'(bf), 16'h0019);
    check("burst last", 16'(bl), 16'h001D);
    wr(8'h27, '{8'h15});
    check("wss off", 16'(wss_on), 16'h0000);
    $display("test autoinc done");
  endtask
  // foreign address refused, alternate accepted, read writes nothing
  task automatic t_address();
    logic ack;
    u_host.phase = 16;
    u_host.start_cond();
    u_host.send_byte(8'h8A, ack);
    check("foreign ack", 16'(ack), 16'h0000);
    u_host.send_byte(8'h5A, ack);
    u_host.send_byte(8'h77, ack);
    u_host.stop_cond();
    check("phase kept", 16'(ph), 16'h0000);
    u_host.start_cond();
    u_host.send_byte({vecr_pkg::ADDR_ALT, 1'b0}, ack);
    check("alt ack", 16'(ack), 16'h0001);
    u_host.send_byte(8'h5A, ack);
    u_host.send_byte(8'h2A, ack);
    u_host.start_cond();
    u_host.send_byte({vecr_pkg::ADDR_PRIMARY, 1'b1}, ack);
    check("read ack", 16'(ack), 16'h0001);
    u_host.send_byte(8'hFF, ack);
    check("read released", 16'(ack), 16'h0000);
    u_host.stop_cond();
    check("phase", 16'(ph), 16'h002A);
    u_host.phase = 8;
    $display("test address done");
  endtask
  task automatic t_format();
    wr(8'h3A, '{8'h00});
    check("chroma 2c", 16'(chf), 16'h0000);
    check("luma 2c", 16'(luf), 16'h0000);
    wr(8'h3A, '{8'h90});
    check("h embedded", 16'(ht), 16'h0000);
    check("v embedded", 16'(vt), 16'h0001);
    check("colour bar", 16'(cbar), 16'h0001);
    wr(8'h5B, '{8'h76, 8'h00, 8'hAA});
    check("u gain", 16'(ug), 16'h0176);
    check("black lvl", 16'(blk), 16'h002A);
    $display("test format done");
  endtask
  task automatic t_rtc();
    rc = 1'b1;
    wr(8'h28, '{8'hE1});
    wr(8'h61, '{8'h01});
    check("colour gated", 16'(cdet), 16'h0000);
    check("field reg", 16'(fseq), 16'h0001);
    wr(8'h62, '{8'h80});
    check("colour link", 16'(cdet), 16'h0001);
    check("field link", 16'(fseq), 16'h0000);
    rf = 1'b1;
    wait_clk(3);
    check("field link 1", 16'(fseq), 16'h0001);
    $display("test rtc done");
  endtask
  // one copy guard slot: start, then sixteen ticks two cycles apart
  task automatic run_cg(input logic en, input logic [15:0] exp);
    logic [15:0] got;
    cgs = 1'b1;
    wait_clk(1);
    cgs = 1'b0;
    check("cg busy", 16'(cgbusy), 16'(en));
    for (int i = 0; i < 16; i++)
    begin
      cgt = 1'b1;
      wait_clk(1);
      cgt = 1'b0;
      wait_clk(1);
      got[i] = cgbit;
    end
    if (en)
      check("cg bits", got, exp);
    check("cg done", 16'(cgbusy), 16'h0000);
  endtask
  // every enable code in both fields; host sets parity in each msb
  task automatic t_copy_guard();
    wr(8'h2A, '{8'h81, 8'h42, 8'h3C, 8'hC3});
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h2E, '{8'(c << 6)});
      fodd = 1'b1;
      run_cg(c[0], 16'h4281);
      fodd = 1'b0;
      run_cg(c[1], 16'hC33C);
    end
    $display("test copy guard done");
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    {rst_i, hpin, vpin, eh, ev, rc, rf, fodd, cgs, cgt} = 10'h200;
    wait_clk(3);
    rst_i = 1'b0;
    wait_clk(3);
    t_reset();
    t_autoinc();
    t_address();
    t_format();
    t_rtc();
    t_copy_guard();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
